// [rtl/agnc_regs.svh]
// Register map and constants of the gain and zone configuration bank
//
// Function
// RL1 - Each channel's samples are scaled by a 4-bit gain code, 1 dB a step from 0001 up to 1011 at 11 dB.
// RL2 - Each channel has its own gain register, reached through its own gain page.
// RL3 - A 0-1-0 pulse of the core reset bit resets the whole digital core of both channels.
// RL4 - New zone selections of both channels take effect only on the core reset pulse.
// RL5 - A per-channel zone enable bit turns explicit zone selection off at 0 and on at 1.
// RL6 - Software sets the zone enable bit before it writes the zone field.
// RL7 - Zone code 000 is the first zone, 001 the second, 010 the third, 011 the fourth.
// RL8 - Channel A and B have separate main pages with core reset and zone registers at equal offsets.
// RL9 - Gain code 0000 passes the samples unscaled.
`ifndef AGNC_REGS_SVH
`define AGNC_REGS_SVH

// ----------------------------------------
// Pages and offsets
// ----------------------------------------
`define AGNC_PG_GAIN_A 24'h610005
`define AGNC_PG_GAIN_B 24'h610105
`define AGNC_PG_MAIN_A 24'h680000
`define AGNC_PG_MAIN_B 24'h680100
`define AGNC_OFS_CORE_RST 12'h000
`define AGNC_OFS_ZONE 12'h0A2
`define AGNC_OFS_GAIN 12'h0A6
`define AGNC_PG_MSB 35
`define AGNC_PG_LSB 12
`define AGNC_OFS_MSB 11

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define AGNC_REG_RST 8'h00
`define AGNC_CR_BIT 0
`define AGNC_ZEN_BIT 3
`define AGNC_ZONE_MSB 2
`define AGNC_GAIN_MSB 3
`define AGNC_GAIN_MAX 4'hB
`define AGNC_ZONE_1ST 3'h0
`define AGNC_ZONE_2ND 3'h1
`define AGNC_ZONE_3RD 3'h2
`define AGNC_ZONE_4TH 3'h3
`define AGNC_OH_1ST 4'h1
`define AGNC_OH_2ND 4'h2
`define AGNC_OH_3RD 4'h4
`define AGNC_OH_4TH 4'h8
`define AGNC_OH_NONE 4'h0

// ----------------------------------------
// Gain coefficients, unity at 4096
// ----------------------------------------
`define AGNC_FRAC 12
`define AGNC_COEF_W 16
`define AGNC_GAIN_TBL {16'h38C5, 16'h3299, 16'h2D18, 16'h2831, \
  16'h23D2, 16'h1FED, 16'h1C74, 16'h195C, 16'h169A, 16'h1425, \
  16'h11F4, 16'h1000}

`endif

// [rtl/agnc_pkg.sv]
// Types of the gain and zone configuration bank
package agnc_pkg;

  typedef enum logic [1:0] {
    AGNC_SEQ_IDLE = 2'b01,
    AGNC_SEQ_ARMED = 2'b10
  } agnc_seq_e;

  typedef struct packed {
    logic cr;
    logic zen;
    logic [2:0] zone;
    logic [3:0] gain;
    logic act_zen;
    logic [2:0] act_zone;
  } agnc_chan_s;

  typedef struct packed {
    logic [35:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } agnc_bus_s;

endpackage

// [rtl/agnc_top.sv]
// Gain, core reset and zone configuration bank for two channels
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "agnc_regs.svh"

module agnc_top import agnc_pkg::*; #(
  parameter int SMP_W = 14
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire agnc_bus_s bus,
  output logic [7:0] reg_rdata,
  // Sample path, index 0 is channel A
  input wire logic [1:0][SMP_W-1:0] smp_in,
  output logic [1:0][SMP_W-1:0] smp_out,
  // Core control
  output logic core_soft_reset_pulse,
  output logic [1:0] zone_select_enable,
  output logic [1:0][2:0] zone_code,
  output logic [1:0][3:0] zone_onehot
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (SMP_W < 4 || SMP_W > 24) begin
    $error("agnc_top: SMP_W out of range");
  end

  localparam int PW = SMP_W + `AGNC_COEF_W + 1;
  localparam logic [12*`AGNC_COEF_W-1:0] GAIN_TBL = `AGNC_GAIN_TBL;

  typedef struct packed {
    agnc_chan_s [1:0] ch;
    agnc_seq_e seq;
    logic core_rst;
    logic [7:0] rdata;
    logic [1:0][SMP_W-1:0] y;
    logic [1:0][3:0] oh;
  } agnc_state_s;

  agnc_state_s s_r;
  agnc_state_s s_nxt;

  logic [23:0] page;
  logic [11:0] ofs;
  logic any_hi;

  assign page = bus.addr[`AGNC_PG_MSB:`AGNC_PG_LSB];
  assign ofs = bus.addr[`AGNC_OFS_MSB:0];

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [23:0] main_pg(input int c);
    main_pg = (c == 0) ? `AGNC_PG_MAIN_A : `AGNC_PG_MAIN_B;
  endfunction

  function automatic logic [23:0] gain_pg(input int c);
    gain_pg = (c == 0) ? `AGNC_PG_GAIN_A : `AGNC_PG_GAIN_B;
  endfunction

  // Codes past 11 dB are not allowed; they fall back to unity
  function automatic logic [`AGNC_COEF_W-1:0] coef(input logic [3:0] g);
    logic [3:0] k;
    k = (g > `AGNC_GAIN_MAX) ? 4'h0 : g;
    coef = GAIN_TBL[k*`AGNC_COEF_W +: `AGNC_COEF_W];
  endfunction

  // Scale and saturate one sample
  function automatic logic [SMP_W-1:0] scale(
    input logic [SMP_W-1:0] x,
    input logic [3:0] g
  );
    logic signed [PW-1:0] p;
    logic signed [PW-1:0] lim_hi;
    logic signed [PW-1:0] lim_lo;
    p = $signed(x) * $signed({1'b0, coef(g)});
    p = p >>> `AGNC_FRAC;
    lim_hi = PW'((1 <<< (SMP_W - 1)) - 1);
    lim_lo = -PW'(1 <<< (SMP_W - 1));
    if (p > lim_hi) begin
      scale = lim_hi[SMP_W-1:0];
    end else if (p < lim_lo) begin
      scale = lim_lo[SMP_W-1:0];
    end else begin
      scale = p[SMP_W-1:0];
    end
  endfunction

  function automatic logic [3:0] zone_dec(
    input logic en,
    input logic [2:0] z
  );
    zone_dec = `AGNC_OH_NONE;
    if (en) begin
      unique case (z)
        `AGNC_ZONE_1ST: zone_dec = `AGNC_OH_1ST;
        `AGNC_ZONE_2ND: zone_dec = `AGNC_OH_2ND;
        `AGNC_ZONE_3RD: zone_dec = `AGNC_OH_3RD;
        `AGNC_ZONE_4TH: zone_dec = `AGNC_OH_4TH;
        default: zone_dec = `AGNC_OH_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.core_rst = 1'b0;
    s_nxt.rdata = `AGNC_REG_RST;
    for (int c = 0; c < 2; c++) begin
      if (bus.wr && page == main_pg(c)) begin
        if (ofs == `AGNC_OFS_CORE_RST) begin
          s_nxt.ch[c].cr = bus.wdata[`AGNC_CR_BIT]; // RL8
        end
        if (ofs == `AGNC_OFS_ZONE) begin
          s_nxt.ch[c].zen = bus.wdata[`AGNC_ZEN_BIT]; // RL5
          s_nxt.ch[c].zone = bus.wdata[`AGNC_ZONE_MSB:0];
        end
      end
      if (bus.wr && page == gain_pg(c) && ofs == `AGNC_OFS_GAIN) begin
        s_nxt.ch[c].gain = bus.wdata[`AGNC_GAIN_MSB:0]; // RL2
      end
      if (bus.rd && page == main_pg(c)) begin
        if (ofs == `AGNC_OFS_CORE_RST) begin
          s_nxt.rdata[`AGNC_CR_BIT] = s_r.ch[c].cr;
        end
        if (ofs == `AGNC_OFS_ZONE) begin
          s_nxt.rdata[`AGNC_ZEN_BIT] = s_r.ch[c].zen;
          s_nxt.rdata[`AGNC_ZONE_MSB:0] = s_r.ch[c].zone;
        end
      end
      if (bus.rd && page == gain_pg(c) && ofs == `AGNC_OFS_GAIN) begin
        s_nxt.rdata[`AGNC_GAIN_MSB:0] = s_r.ch[c].gain;
      end
      // Cleared on the core reset, scaled otherwise
      if (s_r.core_rst) begin
        s_nxt.y[c] = '0; // RL3
      end else begin
        s_nxt.y[c] = scale(smp_in[c], s_r.ch[c].gain); // RL1 RL9
      end
    end
    // Pulse seen when the bits of both pages are back at 0
    any_hi = s_nxt.ch[0].cr | s_nxt.ch[1].cr;
    unique case (s_r.seq)
      AGNC_SEQ_IDLE: begin
        if (any_hi) begin
          s_nxt.seq = AGNC_SEQ_ARMED;
        end
      end
      AGNC_SEQ_ARMED: begin
        if (!any_hi) begin
          s_nxt.seq = AGNC_SEQ_IDLE;
          s_nxt.core_rst = 1'b1; // RL3
          for (int c = 0; c < 2; c++) begin
            s_nxt.ch[c].act_zen = s_nxt.ch[c].zen; // RL4
            s_nxt.ch[c].act_zone = s_nxt.ch[c].zone;
          end
        end
      end
      default: s_nxt.seq = AGNC_SEQ_IDLE;
    endcase
    // Zone decode registered with the applied zone
    for (int c = 0; c < 2; c++) begin
      s_nxt.oh[c] = zone_dec(s_nxt.ch[c].act_zen,
                             s_nxt.ch[c].act_zone); // RL5 RL7
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.seq <= AGNC_SEQ_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = s_r.rdata;
  assign smp_out = s_r.y;
  assign core_soft_reset_pulse = s_r.core_rst;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      zone_select_enable[c] = s_r.ch[c].act_zen;
      zone_code[c] = s_r.ch[c].act_zone;
      zone_onehot[c] = s_r.oh[c];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  gain_unity_a: assert property ( // RL9
    s_r.ch[0].gain == 4'h0 && !s_r.core_rst
    |=> smp_out[0] == $past(smp_in[0]))
    else $error("unity gain does not pass sample");

  gain_step_a: assert property ( // RL1
    s_r.ch[0].gain == 4'h1 && !s_r.core_rst
    && smp_in[0] == SMP_W'(16'h03E8)
    |=> smp_out[0] == SMP_W'(16'h0462))
    else $error("1 dB gain gives wrong sample");

  gain_bad_a: assert property ( // RL1
    s_r.ch[0].gain > `AGNC_GAIN_MAX && !s_r.core_rst
    |=> smp_out[0] == $past(smp_in[0]))
    else $error("illegal gain code not unity");

  gain_indep_a: assert property ( // RL2
    bus.wr && page == `AGNC_PG_GAIN_B
    |=> s_r.ch[0].gain == $past(s_r.ch[0].gain))
    else $error("channel B gain write moved A");

  page_sep_a: assert property ( // RL8
    bus.wr && page == `AGNC_PG_MAIN_A
    |=> s_r.ch[1].cr == $past(s_r.ch[1].cr)
        && s_r.ch[1].zone == $past(s_r.ch[1].zone))
    else $error("channel A page write moved B");

  pulse_cause_a: assert property ( // RL3
    core_soft_reset_pulse
    |-> $past(s_r.seq == AGNC_SEQ_ARMED)
        && !s_r.ch[0].cr && !s_r.ch[1].cr)
    else $error("core reset without 0-1-0 pulse");

  pulse_one_a: assert property ( // RL3
    core_soft_reset_pulse |=> !core_soft_reset_pulse)
    else $error("core reset pulse too long");

  core_clear_a: assert property ( // RL3
    core_soft_reset_pulse
    |=> smp_out[0] == '0 && smp_out[1] == '0)
    else $error("core reset left a channel running");

  zone_hold_a: assert property ( // RL4
    $changed(zone_code) || $changed(zone_select_enable)
    |-> core_soft_reset_pulse)
    else $error("zone applied without core reset");

  zone_off_a: assert property ( // RL5
    !zone_select_enable[0] |-> zone_onehot[0] == `AGNC_OH_NONE)
    else $error("zone active while disabled");

  zone_decode_a: assert property ( // RL7
    zone_select_enable[1] && zone_code[1] == `AGNC_ZONE_4TH
    |-> zone_onehot[1] == `AGNC_OH_4TH)
    else $error("fourth zone decoded wrong");

  read_once_a: assert property (
    !$past(bus.rd) |-> reg_rdata == `AGNC_REG_RST)
    else $error("read data outside read answer");

  gain_max_a: assert property ( // RL1
    s_r.ch[1].gain == `AGNC_GAIN_MAX && !s_r.core_rst
    && smp_in[1] == SMP_W'(16'h3C18)
    |=> smp_out[1] == SMP_W'(16'h3223))
    else $error("11 dB gain gives wrong sample");

  read_gain_a: assert property ( // RL2
    bus.rd && page == `AGNC_PG_GAIN_B && ofs == `AGNC_OFS_GAIN
    |=> reg_rdata[`AGNC_GAIN_MSB:0] == $past(s_r.ch[1].gain))
    else $error("channel B gain read back wrong");

  half_clear_a: assert property ( // RL3
    s_r.ch[0].cr && s_r.ch[1].cr |=> !core_soft_reset_pulse)
    else $error("core reset fired with a page still high");

  zone_load_a: assert property ( // RL4
    core_soft_reset_pulse
    |-> zone_code[0] == s_r.ch[0].zone
        && zone_select_enable[1] == s_r.ch[1].zen)
    else $error("core reset did not load zones");

  zone_first_a: assert property ( // RL7
    zone_select_enable[1] && zone_code[1] == `AGNC_ZONE_1ST
    |-> zone_onehot[1] == `AGNC_OH_1ST)
    else $error("first zone decoded wrong");

  read_zone_a: assert property ( // RL8
    bus.rd && page == `AGNC_PG_MAIN_A && ofs == `AGNC_OFS_ZONE
    |=> reg_rdata[`AGNC_ZEN_BIT] == $past(s_r.ch[0].zen)
        && reg_rdata[`AGNC_ZONE_MSB:0] == $past(s_r.ch[0].zone))
    else $error("channel A zone read back wrong");

  seq_cov: cover property (
    bus.wr && page == `AGNC_PG_MAIN_B ##[1:8] core_soft_reset_pulse);
  gain_cov: cover property (s_r.ch[0].gain == `AGNC_GAIN_MAX);
  zone_cov: cover property (
    zone_select_enable[0] && zone_code[0] == `AGNC_ZONE_2ND);
  gain_bad_cov: cover property (s_r.ch[0].gain > `AGNC_GAIN_MAX);
  both_cov: cover property (s_r.ch[0].cr && s_r.ch[1].cr);

endmodule
`default_nettype wire

// [tb/agnc_top_tb_top.sv]
// Self-checking bench of the gain and zone configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "agnc_regs.svh"

module agnc_top_tb_top import agnc_pkg::*; ();

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  agnc_bus_s bus;
  logic [7:0] reg_rdata;
  logic [1:0][13:0] smp_in;
  logic [1:0][13:0] smp_out;
  logic core_soft_reset_pulse;
  logic [1:0] zone_select_enable;
  logic [1:0][2:0] zone_code;
  logic [1:0][3:0] zone_onehot;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  agnc_top #(.SMP_W(14)) dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .bus(bus),
    .reg_rdata(reg_rdata),
    .smp_in(smp_in),
    .smp_out(smp_out),
    .core_soft_reset_pulse(core_soft_reset_pulse),
    .zone_select_enable(zone_select_enable),
    .zone_code(zone_code),
    .zone_onehot(zone_onehot)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [23:0] pg, input logic [11:0] ofs,
                        input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: {pg, ofs}, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stands one cycle, then returns to zero
  task automatic bus_rd(input logic [23:0] pg, input logic [11:0] ofs,
                        input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: {pg, ofs}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 chk_reg(reg_rdata, exp);
    @(posedge ref_clk);
    #1 chk_reg(reg_rdata, 8'h00);
  endtask

  // Samples settle after the one-cycle output latency
  task automatic set_smp(input logic [13:0] a, input logic [13:0] b);
    @(posedge ref_clk);
    smp_in <= {b, a};
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Core reset pulse, 1 then 0; returns in the pulse cycle
  task automatic pulse_core(input logic [23:0] pg);
    bus_wr(pg, `AGNC_OFS_CORE_RST, 8'h01);
    #1 chk_out({15'h0, core_soft_reset_pulse}, 16'h0000);
    bus_wr(pg, `AGNC_OFS_CORE_RST, 8'h00);
    #1 chk_out({15'h0, core_soft_reset_pulse}, 16'h0001);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    bus_rd(`AGNC_PG_MAIN_A, `AGNC_OFS_CORE_RST, 8'h00);
    bus_rd(`AGNC_PG_MAIN_B, `AGNC_OFS_ZONE, 8'h00);
    bus_rd(`AGNC_PG_GAIN_B, `AGNC_OFS_GAIN, 8'h00);
    bus_wr(24'h123456, 12'h000, 8'hFF);
    bus_rd(24'h123456, 12'h000, 8'h00);
  endtask

  task automatic t_gain;
    set_smp(14'h03E8, 14'h3C18);
    chk_out({2'h0, smp_out[0]}, 16'h03E8);
    chk_out({2'h0, smp_out[1]}, 16'h3C18);
    bus_wr(`AGNC_PG_GAIN_A, `AGNC_OFS_GAIN, 8'hF1);
    bus_wr(`AGNC_PG_GAIN_B, `AGNC_OFS_GAIN, 8'h0B);
    bus_rd(`AGNC_PG_GAIN_A, `AGNC_OFS_GAIN, 8'h01);
    bus_rd(`AGNC_PG_GAIN_B, `AGNC_OFS_GAIN, 8'h0B);
    set_smp(14'h03E8, 14'h3C18);
    // 1 dB coef 4596, 11 dB coef 14533, floor of the product
    chk_out({2'h0, smp_out[0]}, 16'h0462);
    chk_out({2'h0, smp_out[1]}, 16'h3223);
    bus_wr(`AGNC_PG_GAIN_A, `AGNC_OFS_GAIN, 8'h0B);
    set_smp(14'h0FA0, 14'h3C18);
    chk_out({2'h0, smp_out[0]}, 16'h1FFF);
    bus_wr(`AGNC_PG_GAIN_A, `AGNC_OFS_GAIN, 8'h0C);
    set_smp(14'h03E8, 14'h3C18);
    chk_out({2'h0, smp_out[0]}, 16'h03E8);
  endtask

  task automatic t_zone_defer;
    bus_wr(`AGNC_PG_MAIN_A, `AGNC_OFS_ZONE, 8'h08);
    bus_wr(`AGNC_PG_MAIN_A, `AGNC_OFS_ZONE, 8'h0B);
    bus_wr(`AGNC_PG_MAIN_B, `AGNC_OFS_ZONE, 8'h08);
    bus_wr(`AGNC_PG_MAIN_B, `AGNC_OFS_ZONE, 8'h09);
    bus_rd(`AGNC_PG_MAIN_A, `AGNC_OFS_ZONE, 8'h0B);
    chk_out({8'h0, zone_select_enable, zone_code}, 16'h0000);
    pulse_core(`AGNC_PG_MAIN_A);
    chk_out({8'h0, zone_select_enable, zone_code}, 16'h00CB);
    chk_out({8'h0, zone_onehot}, 16'h0028);
    @(posedge ref_clk);
    #1 chk_out({15'h0, core_soft_reset_pulse}, 16'h0000);
    chk_out({2'h0, smp_out[0]}, 16'h0000);
    chk_out({2'h0, smp_out[1]}, 16'h0000);
  endtask

  task automatic t_zone_codes;
    for (int z = 0; z < 4; z++) begin
      bus_wr(`AGNC_PG_MAIN_B, `AGNC_OFS_ZONE, 8'h08 | 8'(z));
      pulse_core(`AGNC_PG_MAIN_B);
      chk_out({12'h0, zone_onehot[1]}, 16'h0001 << z);
    end
    bus_wr(`AGNC_PG_MAIN_B, `AGNC_OFS_ZONE, 8'h02);
    pulse_core(`AGNC_PG_MAIN_B);
    chk_out({14'h0, zone_select_enable}, 16'h0001);
    chk_out({12'h0, zone_onehot[1]}, 16'h0000);
  endtask

  task automatic t_both_pages;
    bus_wr(`AGNC_PG_MAIN_A, `AGNC_OFS_CORE_RST, 8'h01);
    bus_wr(`AGNC_PG_MAIN_B, `AGNC_OFS_CORE_RST, 8'h01);
    bus_rd(`AGNC_PG_MAIN_A, `AGNC_OFS_CORE_RST, 8'h01);
    bus_wr(`AGNC_PG_MAIN_A, `AGNC_OFS_CORE_RST, 8'h00);
    #1 chk_out({15'h0, core_soft_reset_pulse}, 16'h0000);
    bus_wr(`AGNC_PG_MAIN_B, `AGNC_OFS_CORE_RST, 8'h00);
    #1 chk_out({15'h0, core_soft_reset_pulse}, 16'h0001);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    bus <= '0;
    smp_in <= '0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_vals();
    t_gain();
    t_zone_defer();
    t_zone_codes();
    t_both_pages();
    report_and_stop();
  end

endmodule
`default_nettype wire
